// ==== logic/rivm_ctl_if.sv ====
// Control link between the mapper top and its select-bit sequencer.
// Both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface rivm_ctl_if;
  logic wr_stb;
  logic wr_chg_en;
  logic wr_sel;
  logic sel;
  logic chg_en;
  logic hold_off;

  modport top (output wr_stb, output wr_chg_en, output wr_sel,
               input sel, input chg_en, input hold_off);
  modport seq (input wr_stb, input wr_chg_en, input wr_sel,
               output sel, output chg_en, output hold_off);
endinterface
`default_nettype wire

// ==== logic/rivm_pkg.sv ====
// Constants shared by the reset and interrupt vector mapper.
// Assumes a word-addressed program memory of 16-bit addresses.
package rivm_pkg;

  // ------------------------------------------------------------
  // Vector table
  // ------------------------------------------------------------
  localparam logic [15:0] RIVM_RESET_APP_ADDR = 16'h0000;
  localparam logic [15:0] RIVM_TABLE_OFFSET   = 16'h0002;
  localparam int          RIVM_NUM_SRC_MAX    = 24;
  localparam int          RIVM_NUM_SRC_SMALL  = 22;
  localparam int          RIVM_IDX_W          = 5;

  // Source indices, zero based after the reset vector
  // external and pin groups
  localparam logic [4:0] RIVM_SRC_EXT_IRQ_ZERO = 5'h00;
  localparam logic [4:0] RIVM_SRC_PCG0         = 5'h01;
  localparam logic [4:0] RIVM_SRC_PCG1         = 5'h02;
  localparam logic [4:0] RIVM_SRC_T2_CMP       = 5'h03;
  localparam logic [4:0] RIVM_SRC_T2_OVF       = 5'h04;
  localparam logic [4:0] RIVM_SRC_T1_CAPT      = 5'h05;
  localparam logic [4:0] RIVM_SRC_T1_CMPA      = 5'h06;
  localparam logic [4:0] RIVM_SRC_T1_CMPB      = 5'h07;
  localparam logic [4:0] RIVM_SRC_T1_OVF       = 5'h08;
  localparam logic [4:0] RIVM_SRC_T0_CMP       = 5'h09;
  localparam logic [4:0] RIVM_SRC_T0_OVF       = 5'h0A;
  localparam logic [4:0] RIVM_SRC_SPI_DONE     = 5'h0B;
  localparam logic [4:0] RIVM_SRC_RX_DONE      = 5'h0C;
  localparam logic [4:0] RIVM_SRC_TX_EMPTY     = 5'h0D;
  localparam logic [4:0] RIVM_SRC_TX_DONE      = 5'h0E;
  localparam logic [4:0] RIVM_SRC_USER_START   = 5'h0F;
  localparam logic [4:0] RIVM_SRC_USER_OVF     = 5'h10;
  localparam logic [4:0] RIVM_SRC_ACMP         = 5'h11;
  localparam logic [4:0] RIVM_SRC_ADC_DONE     = 5'h12;
  localparam logic [4:0] RIVM_SRC_EEPROM_RDY   = 5'h13;
  localparam logic [4:0] RIVM_SRC_STORE_RDY    = 5'h14;
  localparam logic [4:0] RIVM_SRC_LCD_SOF      = 5'h15;
  localparam logic [4:0] RIVM_SRC_PCG2         = 5'h16;
  localparam logic [4:0] RIVM_SRC_PCG3         = 5'h17;

  // ------------------------------------------------------------
  // Change sequence and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] RIVM_CHG_WINDOW_CYC = 3'h4;
  localparam logic       RIVM_SEL_RST        = 1'b0;
  localparam logic       RIVM_FUSE_PROG      = 1'b0;

  // Vector address = base + 2 * index
  function automatic logic [15:0] rivm_vec_addr(
    input logic [15:0] base,
    input logic [4:0]  idx
  );
    rivm_vec_addr = base + {10'h000, idx, 1'b0};
  endfunction

endpackage

// ==== logic/rivm_sel_seq.sv ====
// Timed change sequence for the vector-select bit.
// Assumes one control write per cycle, driven from the core clock.
`timescale 1ns/100ps
`default_nettype none
module rivm_sel_seq
  import rivm_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  // Control link
  rivm_ctl_if.seq   ctl
);

  logic [2:0] win_cnt_r;
  logic       sel_r;
  logic       hold_r;
  logic       post_r;
  logic       open_w;
  logic       set_chg_w;
  logic       sel_wr_w;

  assign open_w    = (win_cnt_r != 3'h0);
  assign set_chg_w = ctl.wr_stb && ctl.wr_chg_en;
  assign sel_wr_w  = ctl.wr_stb && !ctl.wr_chg_en && open_w;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      win_cnt_r <= 3'h0;
      sel_r     <= RIVM_SEL_RST;
    end else if (set_chg_w) begin
      win_cnt_r <= RIVM_CHG_WINDOW_CYC;
    end else if (sel_wr_w) begin
      win_cnt_r <= 3'h0;
      sel_r     <= ctl.wr_sel;
    end else if (open_w) begin
      win_cnt_r <= win_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      post_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      post_r <= sel_wr_w;
      hold_r <= set_chg_w || (open_w && !sel_wr_w && win_cnt_r != 3'h1)
                || sel_wr_w;
    end
  end

  assign ctl.sel      = sel_r;
  assign ctl.chg_en   = open_w;
  assign ctl.hold_off = hold_r || post_r || set_chg_w;

  chg_window_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    set_chg_w ##1 (!ctl.wr_stb)[*4] |=> !open_w)
    else $error("change enable outlived its window");

  sel_guard_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    !open_w |=> $stable(sel_r))
    else $error("select changed outside the window");

  hold_start_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    set_chg_w ##1 (!ctl.wr_stb)[*4] |-> ctl.hold_off)
    else $error("interrupts not held through the window");

  sequence sel_write_s;
    sel_wr_w;
  endsequence

  hold_after_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    sel_write_s |=> ctl.hold_off)
    else $error("hold dropped before next instruction");

endmodule // rivm_sel_seq
`default_nettype wire

// ==== logic/rivm_top.sv ====
// Reset and interrupt vector mapper for an 8-bit core.
// Assumes pending/enable flags come from logic on the same clock and the
// core pulses vec_ack_in when it has taken the presented vector.
//
// What this block does
// - Unprogrammed fuse resets to address zero
// - Programmed fuse resets to boot address
// - Select set adds boot start to vectors
// - Table base 0x0002 or boot plus 0x0002
// - Fuse value one unprogrammed, zero programmed
// - External zero, pin groups zero, one
// - Timer two compare and overflow vectors
// - Timer one capture, compares, overflow vectors
// - Timer zero compare and overflow vectors
// - Serial peripheral and USART event vectors
// - Universal serial start and overflow vectors
// - Comparator, ADC, EEPROM ready vectors
// - Store-program ready and frame start vectors
// - Pin groups two, three only large variant
// - Vector only enabled, pending sources
// - Select changes only in four-cycle window
// - Interrupts held during change sequence
`timescale 1ns/100ps
`default_nettype none
module rivm_top
  import rivm_pkg::*;
#(
  parameter int          NUM_SRC        = RIVM_NUM_SRC_MAX,
  parameter logic [15:0] BOOT_RESET_ADDR = 16'h3800
)(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // Fuse and control writes
  input  wire logic        boot_reset_fuse_in,
  input  wire logic        ctl_wr_in,
  input  wire logic        vector_change_enable_in,
  input  wire logic        vector_select_in,
  // Interrupt sources
  input  wire logic        global_irq_en_in,
  input  wire logic [23:0] irq_pending_in,
  input  wire logic [23:0] irq_enable_in,
  input  wire logic        vec_ack_in,
  // Core fetch side
  output logic [15:0]      reset_addr_out,
  output logic             vec_valid_out,
  output logic [15:0]      vec_addr_out,
  output logic [4:0]       vec_idx_out,
  output logic             vector_select_out,
  output logic             vector_change_enable_out
);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  // only two variants exist
  if (NUM_SRC != RIVM_NUM_SRC_MAX && NUM_SRC != RIVM_NUM_SRC_SMALL) begin
    $error("NUM_SRC must be 22 or 24");
  end

  // ------------------------------------------------------------
  // Select-bit sequencer
  // ------------------------------------------------------------
  rivm_ctl_if ctl ();

  assign ctl.wr_stb    = ctl_wr_in;
  assign ctl.wr_chg_en = vector_change_enable_in;
  assign ctl.wr_sel    = vector_select_in;

  rivm_sel_seq u_seq (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .ctl        (ctl)
  );

  // ------------------------------------------------------------
  // Reset target and table base
  // ------------------------------------------------------------
  logic        fuse_meta_r;
  logic        fuse_sync_r;
  logic [1:0]  fill_r;
  logic        fuse_r;
  logic        fuse_cap_r;
  logic [15:0] reset_addr_w;
  logic [15:0] table_base_w;

  // Fuse level comes from outside the clock: two flops before use
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fuse_meta_r <= 1'b1;
      fuse_sync_r <= 1'b1;
      fill_r      <= 2'h0;
    end else begin
      fuse_meta_r <= boot_reset_fuse_in;
      fuse_sync_r <= fuse_meta_r;
      fill_r      <= {fill_r[0], 1'b1};
    end
  end

  // Caught once, only after the synchroniser has filled
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fuse_cap_r <= 1'b0;
      fuse_r     <= 1'b1;
    end else if (fill_r[1] && !fuse_cap_r) begin
      fuse_cap_r <= 1'b1;
      fuse_r     <= fuse_sync_r;
    end
  end

  assign reset_addr_w = (fuse_r == RIVM_FUSE_PROG) ? BOOT_RESET_ADDR
                                                   : RIVM_RESET_APP_ADDR;
  assign table_base_w = ctl.sel ? (BOOT_RESET_ADDR + RIVM_TABLE_OFFSET)
                                : RIVM_TABLE_OFFSET;

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic [23:0] variant_mask_w;
  logic [23:0] req_w;
  logic [4:0]  win_idx_w;
  logic        any_w;
  logic        irq_ok_w;

  // small variant masks groups two, three
  assign variant_mask_w = (NUM_SRC == RIVM_NUM_SRC_MAX) ? 24'hFFFFFF
                                                        : 24'h3FFFFF;
  assign req_w    = irq_pending_in & irq_enable_in & variant_mask_w;
  assign any_w    = |req_w;
  // sequence holds off interrupts, global flag untouched
  assign irq_ok_w = global_irq_en_in && !ctl.hold_off;

  always_comb begin
    win_idx_w = 5'h00;
    for (int i = 23; i >= 0; i--) begin
      if (req_w[i]) begin
        win_idx_w = i[4:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Presented vector
  // ------------------------------------------------------------
  logic        valid_r;
  logic [15:0] addr_r;
  logic [4:0]  idx_r;
  logic [15:0] rst_addr_r;
  logic        sel_out_r;
  logic        chg_out_r;
  logic        load_w;

  // Hold the presented vector steady until the core takes it
  assign load_w = !valid_r || vec_ack_in;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      valid_r <= 1'b0;
      addr_r  <= RIVM_RESET_APP_ADDR;
      idx_r   <= 5'h00;
    end else if (load_w) begin
      valid_r <= any_w && irq_ok_w;
      addr_r  <= rivm_vec_addr(table_base_w, win_idx_w);
      idx_r   <= win_idx_w;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_addr_r <= RIVM_RESET_APP_ADDR;
      sel_out_r  <= RIVM_SEL_RST;
      chg_out_r  <= 1'b0;
    end else begin
      rst_addr_r <= reset_addr_w;
      sel_out_r  <= ctl.sel;
      chg_out_r  <= ctl.chg_en;
    end
  end

  assign reset_addr_out           = rst_addr_r;
  assign vec_valid_out            = valid_r;
  assign vec_addr_out             = addr_r;
  assign vec_idx_out              = idx_r;
  assign vector_select_out        = sel_out_r;
  assign vector_change_enable_out = chg_out_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // unprogrammed fuse target
  reset_zero_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    fuse_cap_r && fuse_r |=> rst_addr_r == 16'h0000)
    else $error("reset target not zero");

  reset_boot_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    fuse_cap_r && !fuse_r |=> rst_addr_r == BOOT_RESET_ADDR)
    else $error("reset target not boot address");

  vec_reloc_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    load_w && any_w && irq_ok_w && ctl.sel |=>
      addr_r == BOOT_RESET_ADDR + 16'h0002 + {10'h000, idx_r, 1'b0})
    else $error("relocated vector address wrong");

  vec_app_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    load_w && any_w && irq_ok_w && !ctl.sel |=>
      addr_r == 16'h0002 + {10'h000, idx_r, 1'b0})
    else $error("application vector address wrong");

  pcg_absent_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    NUM_SRC == RIVM_NUM_SRC_SMALL && valid_r |-> idx_r < 5'h16)
    else $error("absent source vectored");

  vec_cause_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    $rose(valid_r) |-> $past(any_w) && $past(global_irq_en_in))
    else $error("vector without enabled request");

  vec_prio_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    load_w && any_w && irq_ok_w |=>
      (($past(req_w) & ((24'h000001 << idx_r) - 24'h000001)) == 24'h0))
    else $error("lower pending source skipped");

  vec_hold_a: assert property (@(posedge clk_sys_in)
    disable iff (!reset_n_in)
    load_w && ctl.hold_off |=> !valid_r)
    else $error("vector presented during hold off");

endmodule // rivm_top
`default_nettype wire

// ==== verif/reset_irq_vector_mapper_tb_top.sv ====
// Bench for the vector mapper: raises sources, checks reset and vectors.
// Assumes the core model acks every presented vector.
`timescale 1ns/100ps
`default_nettype none
module reset_irq_vector_mapper_tb_top;
  import rivm_pkg::*;
  localparam logic [15:0] BOOT = 16'h1C00;
  logic        clk_sys_in, reset_n_in, fuse, wr, chg, sel, gie, ack;
  logic        valid, valid2, sel_o, chg_o, sel_exp;
  logic [23:0] pend, en, raise;
  logic [3:0]  dly;
  logic [15:0] rst_a, addr;
  logic [4:0]  idx;
  logic [20:0] e;
  logic [20:0] exp_q[$];
  int          num_errors, num_checks, seed, h;

  rivm_top #(.NUM_SRC(24), .BOOT_RESET_ADDR(BOOT)) uut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .boot_reset_fuse_in(fuse), .ctl_wr_in(wr),
    .vector_change_enable_in(chg), .vector_select_in(sel),
    .global_irq_en_in(gie), .irq_pending_in(pend), .irq_enable_in(en),
    .vec_ack_in(ack), .reset_addr_out(rst_a), .vec_valid_out(valid),
    .vec_addr_out(addr), .vec_idx_out(idx), .vector_select_out(sel_o),
    .vector_change_enable_out(chg_o));
  // Small variant; never acked, only watched for absent sources
  rivm_top #(.NUM_SRC(22), .BOOT_RESET_ADDR(BOOT)) uut_small (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .boot_reset_fuse_in(fuse), .ctl_wr_in(wr),
    .vector_change_enable_in(chg), .vector_select_in(sel),
    .global_irq_en_in(gie), .irq_pending_in(pend), .irq_enable_in(en),
    .vec_ack_in(1'b0), .reset_addr_out(), .vec_valid_out(valid2),
    .vec_addr_out(), .vec_idx_out(), .vector_select_out(),
    .vector_change_enable_out());
  rivm_core_model core (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .raise_in(raise),
    .delay_in(dly), .vec_valid_in(valid), .vec_idx_in(idx),
    .pending_out(pend), .vec_ack_out(ack));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic rst(input logic f);
    @(negedge clk_sys_in);
    reset_n_in <= 1'b0;
    fuse       <= f;
    exp_q.delete();
    cyc(3);
    reset_n_in <= 1'b1;
    cyc(5);
  endtask
  task automatic fire(input logic [23:0] m);
    @(negedge clk_sys_in);
    raise <= m;
    for (int i = 0; i < 24; i++)
      if (m[i])
        exp_q.push_back({5'(i), (sel_exp ? BOOT : 16'h0000) + 16'h0002
                         + 16'(2 * i)});
    @(negedge clk_sys_in);
    raise <= '0;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk_sys_in);
      if (valid !== 1'b0)
        h++;
    end
  endtask
  task automatic drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(24'(exp_q.size()), 24'h0);
    cyc(2);
  endtask
  task automatic ctl(input logic c, input logic s);
    @(negedge clk_sys_in);
    wr  <= 1'b1;
    chg <= c;
    sel <= s;
    @(negedge clk_sys_in);
    wr  <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, scoreboard and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // Vector taken at the ack edge is compared with the oldest note
  always @(posedge clk_sys_in)
    if (reset_n_in === 1'b1 && valid === 1'b1 && ack === 1'b1) begin
      if (exp_q.size() == 0)
        check(24'h0, 24'h1);
      else begin
        e = exp_q.pop_front();
        check({3'h0, idx, addr}, {3'h0, e});
      end
    end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hcdde;
    {wr, chg, sel, raise, dly, sel_exp, h} = '0;
    {num_errors, num_checks} = '0;
    reset_n_in = 1'b0;
    fuse = 1'b1;
    gie  = 1'b1;
    en   = '1;
    rst(1'b1);
    check(24'(rst_a), 24'h0000);
    check(24'({sel_o, chg_o}), 24'h0);
    fire(24'hC00000);
    h = 0;
    repeat (6) @(negedge clk_sys_in) if (valid2 !== 1'b0) h++;
    check(24'(h), 24'h0);
    drain();
    $display("test variant done");
    for (int i = 0; i < 24; i++) begin
      dly <= 4'(i % 3);
      fire(24'h000001 << i);
      drain();
    end
    $display("test table done");
    h = 0;
    gie <= 1'b0;
    fire(24'h000020);
    quiet(6);
    gie <= 1'b1;
    drain();
    en[7] <= 1'b0;
    fire(24'h000080);
    quiet(6);
    check(24'(h), 24'h0);
    en <= '1;
    drain();
    repeat (4) begin
      dly <= 4'($random(seed));
      fire(24'($random(seed)));
      drain();
    end
    $display("test gating and priority done");
    // Source raised with the enable write must wait out the hold
    sel_exp = 1'b1;
    h = 0;
    @(negedge clk_sys_in);
    wr    <= 1'b1;
    chg   <= 1'b1;
    raise <= 24'h000008;
    exp_q.push_back({5'h03, BOOT + 16'h0008});
    @(negedge clk_sys_in);
    wr    <= 1'b0;
    raise <= '0;
    quiet(1);
    ctl(1'b0, 1'b1);
    quiet(1);
    check(24'(h), 24'h0);
    drain();
    check(24'(sel_o), 24'h1);
    ctl(1'b1, 1'b0);
    cyc(3);
    check(24'(chg_o), 24'h1);
    ctl(1'b0, 1'b0);
    cyc(3);
    check(24'(chg_o), 24'h0);
    check(24'(sel_o), 24'h1);
    fire(24'($random(seed)));
    drain();
    ctl(1'b1, 1'b0);
    ctl(1'b0, 1'b0);
    sel_exp = 1'b0;
    cyc(3);
    check(24'(sel_o), 24'h0);
    $display("test select done");
    rst(1'b0);
    check(24'(rst_a), 24'(BOOT));
    fire(24'h200000);
    drain();
    $display("test boot reset done");
    conclude();
  end
endmodule // reset_irq_vector_mapper_tb_top
`default_nettype wire

// ==== verif/rivm_core_model.sv ====
// Core-side partner: holds per-source pending flags and takes vectors.
// Assumes the bench raises flags as one-cycle pulses on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module rivm_core_model (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // Bench side
  input  wire logic [23:0] raise_in,
  input  wire logic [3:0]  delay_in,
  // Mapper side
  input  wire logic        vec_valid_in,
  input  wire logic [4:0]  vec_idx_in,
  output logic [23:0]      pending_out,
  output logic             vec_ack_out
);
  logic [23:0] pend_r;
  logic [3:0]  wait_r;
  logic [23:0] pend_nxt;

  assign pend_nxt    = pend_r | raise_in;
  assign pending_out = pend_nxt;

  // Flag is dropped with the ack so the edge never sees it again
  always_ff @(negedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_r      <= '0;
      wait_r      <= '0;
      vec_ack_out <= 1'b0;
    end else if (vec_ack_out) begin
      pend_r      <= pend_nxt;
      wait_r      <= '0;
      vec_ack_out <= 1'b0;
    end else if (vec_valid_in && wait_r >= delay_in) begin
      pend_r      <= pend_nxt & ~(24'h000001 << vec_idx_in);
      vec_ack_out <= 1'b1;
    end else begin
      pend_r <= pend_nxt;
      if (vec_valid_in)
        wait_r <= wait_r + 4'h1;
    end
  end
endmodule // rivm_core_model
`default_nettype wire
